// ### common/osse_pkg.sv
// Shared constants and types for the output sequence step engine.
package osse_pkg;
  localparam int unsigned MAX_SEQ     = 50;
  localparam int unsigned MAX_STEP    = 21;
  localparam int unsigned PAUSE_LAST  = 20;
  localparam int unsigned NEST_DEPTH  = 10;
  localparam int unsigned SEQ_W       = 6;
  localparam int unsigned STEP_W      = 5;
  localparam int unsigned PARAM_W     = 16;
  localparam int unsigned TYPE_W      = 3;
  localparam logic [STEP_W-1:0] STEP_FIRST = 5'h01;
  localparam logic [STEP_W-1:0] STEP_LAST  = 5'h15;
  localparam logic [STEP_W-1:0] STEP_PAUSE = 5'h14;
  localparam logic [15:0] NVM_ERR_NONE = 16'h0000;

  typedef enum logic [TYPE_W-1:0] {
    OSSE_EMPTY  = 3'h0,
    OSSE_LOOP   = 3'h1,
    OSSE_NEXT   = 3'h2,
    OSSE_STOP   = 3'h3,
    OSSE_GOTO   = 3'h4,
    OSSE_PAUSE  = 3'h5,
    OSSE_RETURN = 3'h6,
    OSSE_OUTPUT = 3'h7
  } osse_step_t;

  typedef enum logic [3:0] {
    OSSE_CMD_NONE    = 4'h0,
    OSSE_CMD_DEFINE  = 4'h1,
    OSSE_CMD_QUERY   = 4'h2,
    OSSE_CMD_ALLOC   = 4'h3,
    OSSE_CMD_DEL_SEL = 4'h4,
    OSSE_CMD_DEL_ALL = 4'h5,
    OSSE_CMD_SAVE    = 4'h6,
    OSSE_CMD_RUN     = 4'h7,
    OSSE_CMD_RESUME  = 4'h8
  } osse_cmd_t;

  typedef enum logic [4:0] {
    OSSE_IDLE   = 5'b00001,
    OSSE_FETCH  = 5'b00010,
    OSSE_EXEC   = 5'b00100,
    OSSE_PAUSED = 5'b01000,
    OSSE_FAULT  = 5'b10000
  } osse_state_t;
endpackage : osse_pkg

// ### hw/osse_loop_stack.sv
// Last-in first-out stack of loop return points and remaining counts.
module osse_loop_stack
  import osse_pkg::*;
#(
  parameter int unsigned DEPTH = NEST_DEPTH
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               clear,
  input  wire logic               push,
  input  wire logic               pop,
  input  wire logic               dec,
  input  wire logic [SEQ_W-1:0]   push_seq,
  input  wire logic [STEP_W-1:0]  push_step,
  input  wire logic [PARAM_W-1:0] push_count,
  output logic      [SEQ_W-1:0]   top_seq,
  output logic      [STEP_W-1:0]  top_step,
  output logic      [PARAM_W-1:0] top_count,
  output logic                    empty,
  output logic                    full
);
  if (DEPTH < 1 || DEPTH > 15)
  begin : g_bad_depth
    $error("osse_loop_stack: DEPTH out of range");
  end

  logic [SEQ_W-1:0]   seq_mem [DEPTH];
  logic [STEP_W-1:0]  step_mem[DEPTH];
  logic [PARAM_W-1:0] cnt_mem [DEPTH];
  logic [3:0]         level;
  logic [3:0]         next_level;
  logic [3:0]         top_idx;

  assign top_idx   = (level == 4'h0) ? 4'h0 : level - 4'h1;
  assign top_seq   = seq_mem[top_idx];
  assign top_step  = step_mem[top_idx];
  assign top_count = cnt_mem[top_idx];
  assign empty     = (level == 4'h0);
  assign full      = (level == 4'(DEPTH));

  always_comb
  begin
    next_level = level;
    if (clear)
      next_level = 4'h0;
    else if (push && !full)
      next_level = level + 4'h1;
    else if (pop && !empty)
      next_level = level - 4'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      level <= 4'h0;
    else
      level <= next_level;
    if (!clear && push && !full)
    begin
      seq_mem[level[3:0]]  <= push_seq;
      step_mem[level[3:0]] <= push_step;
      cnt_mem[level[3:0]]  <= push_count;
    end
    else if (!clear && dec && !empty)
      cnt_mem[top_idx] <= top_count - 16'h0001;
  end
endmodule // osse_loop_stack

// ### hw/osse_engine.sv
// Sequence step engine: storage, loop, goto, pause and save handling.
module osse_engine
  import osse_pkg::*;
#(
  parameter int unsigned SEQS  = MAX_SEQ,
  parameter int unsigned STEPS = MAX_STEP
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               cmd_valid,
  input  wire logic [3:0]         cmd_code,
  input  wire logic [SEQ_W-1:0]   cmd_seq,
  input  wire logic [STEP_W-1:0]  cmd_step,
  input  wire logic [TYPE_W-1:0]  cmd_type,
  input  wire logic [PARAM_W-1:0] cmd_param,
  output logic                    cmd_error,
  output logic                    query_valid,
  output logic      [TYPE_W-1:0]  query_type,
  output logic      [PARAM_W-1:0] query_param,
  output logic                    running,
  output logic                    paused,
  output logic                    out_strobe,
  output logic      [PARAM_W-1:0] out_param,
  output logic                    exec_fault
);
  if (SEQS != MAX_SEQ || STEPS != MAX_STEP)
  begin : g_bad_geometry
    $error("osse_engine: storage geometry must match the encoding");
  end

  logic [TYPE_W-1:0]  ram_type [SEQS][STEPS];
  logic [PARAM_W-1:0] ram_par  [SEQS][STEPS];
  logic [TYPE_W-1:0]  nvm_type [SEQS][STEPS];
  logic [PARAM_W-1:0] nvm_par  [SEQS][STEPS];
  logic [SEQS-1:0]    in_use;
  logic [SEQS-1:0]    next_in_use;

  osse_state_t        state;
  osse_state_t        next_state;
  logic [SEQ_W-1:0]   pc_seq;
  logic [SEQ_W-1:0]   next_pc_seq;
  logic [STEP_W-1:0]  pc_step;
  logic [STEP_W-1:0]  next_pc_step;
  logic [TYPE_W-1:0]  cur_type;
  logic [PARAM_W-1:0] cur_par;
  logic [TYPE_W-1:0]  next_cur_type;
  logic [PARAM_W-1:0] next_cur_par;
  logic               next_cmd_error;
  logic               next_query_valid;
  logic [TYPE_W-1:0]  next_query_type;
  logic [PARAM_W-1:0] next_query_param;
  logic               next_out_strobe;
  logic [PARAM_W-1:0] next_out_param;
  logic               next_exec_fault;

  logic               st_clear;
  logic               st_push;
  logic               st_pop;
  logic               st_dec;
  logic [SEQ_W-1:0]   st_seq;
  logic [STEP_W-1:0]  st_step;
  logic [PARAM_W-1:0] st_count;
  logic               st_empty;
  logic               st_full;

  logic               seq_ok;
  logic               step_ok;
  logic               type_ok;
  logic               wr_define;
  logic               do_alloc;
  logic               do_del_sel;
  logic               do_del_all;
  logic               do_save;
  logic [SEQ_W-1:0]   free_slot;
  logic               free_found;

  // The loop stack holds the return location and remaining count.
  osse_loop_stack #(
    .DEPTH(NEST_DEPTH)
  ) u_stack (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clear     (st_clear),
    .push      (st_push),
    .pop       (st_pop),
    .dec       (st_dec),
    .push_seq  (pc_seq),
    .push_step (pc_step),
    .push_count(cur_par),
    .top_seq   (st_seq),
    .top_step  (st_step),
    .top_count (st_count),
    .empty     (st_empty),
    .full      (st_full)
  );

  assign seq_ok  = (cmd_seq < SEQ_W'(SEQS)) && in_use[cmd_seq];
  assign step_ok = (cmd_step >= STEP_FIRST) && (cmd_step <= STEP_LAST);

  // Step ranges per type; outputs fit 20 steps.
  always_comb
  begin
    case (cmd_type)
      OSSE_PAUSE,
      OSSE_OUTPUT,
      OSSE_LOOP,
      OSSE_NEXT:   type_ok = (cmd_step <= STEP_PAUSE);
      OSSE_STOP,
      OSSE_GOTO,
      OSSE_RETURN: type_ok = 1'b1;
      default:     type_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    free_slot  = '0;
    free_found = 1'b0;
    for (int i = SEQS - 1; i >= 0; i--)
    begin
      if (!in_use[i])
      begin
        free_slot  = SEQ_W'(i);
        free_found = 1'b1;
      end
    end
  end

  // Host commands other than resume are only taken while no sequence runs.
  always_comb
  begin
    logic idle_cmd;
    idle_cmd   = cmd_valid && (state == OSSE_IDLE);
    wr_define  = idle_cmd && cmd_code == OSSE_CMD_DEFINE
                 && seq_ok && step_ok && type_ok;
    do_alloc   = idle_cmd && cmd_code == OSSE_CMD_ALLOC
                 && free_found;
    do_del_sel = idle_cmd && cmd_code == OSSE_CMD_DEL_SEL && seq_ok;
    do_del_all = idle_cmd && cmd_code == OSSE_CMD_DEL_ALL;
    do_save    = idle_cmd && cmd_code == OSSE_CMD_SAVE && seq_ok;
  end

  // Allocation marks a free slot in edit; at most fifty exist.
  always_comb
  begin
    next_in_use = in_use;
    if (do_alloc)
      next_in_use[free_slot] = 1'b1;
    if (do_del_sel)
      next_in_use[cmd_seq] = 1'b0;
    if (do_del_all)
      next_in_use = '0;
  end

  // Storage writes: define, preload, delete and save.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      in_use <= '0;
    else
      in_use <= next_in_use;
    for (int s = 0; s < SEQS; s++)
    begin
      for (int t = 0; t < STEPS; t++)
      begin
        if (do_del_all || (do_del_sel && cmd_seq == SEQ_W'(s)))
        begin
          ram_type[s][t] <= OSSE_EMPTY;
          nvm_type[s][t] <= OSSE_EMPTY;
        end
        else if (do_alloc && free_slot == SEQ_W'(s))
          ram_type[s][t] <= (t == STEPS - 1) ? OSSE_STOP
                                             : OSSE_EMPTY;
        else if (do_save && cmd_seq == SEQ_W'(s))
        begin
          nvm_type[s][t] <= ram_type[s][t];
          nvm_par[s][t]  <= ram_par[s][t];
        end
      end
    end
    if (wr_define)
    begin
      ram_type[cmd_seq][cmd_step - STEP_FIRST] <= cmd_type;
      ram_par[cmd_seq][cmd_step - STEP_FIRST]  <= cmd_param;
    end
  end

  // Sequencer: fetch a step, then act on its type.
  always_comb
  begin
    next_state       = state;
    next_pc_seq      = pc_seq;
    next_pc_step     = pc_step;
    next_cur_type    = cur_type;
    next_cur_par     = cur_par;
    next_cmd_error   = 1'b0;
    next_query_valid = 1'b0;
    next_query_type  = query_type;
    next_query_param = query_param;
    next_out_strobe  = 1'b0;
    next_out_param   = out_param;
    next_exec_fault  = exec_fault;
    st_clear         = 1'b0;
    st_push          = 1'b0;
    st_pop           = 1'b0;
    st_dec           = 1'b0;
    if (cmd_valid && state == OSSE_IDLE)
    begin
      case (cmd_code)
        OSSE_CMD_DEFINE:  next_cmd_error = !(seq_ok && step_ok && type_ok);
        OSSE_CMD_ALLOC:   next_cmd_error = !free_found;
        OSSE_CMD_DEL_SEL,
        OSSE_CMD_SAVE:    next_cmd_error = !seq_ok;
        OSSE_CMD_DEL_ALL: next_cmd_error = 1'b0;
        OSSE_CMD_QUERY:
        begin
          next_cmd_error = !(seq_ok && step_ok);
          if (seq_ok && step_ok)
          begin
            next_query_valid = 1'b1;
            next_query_type  = ram_type[cmd_seq][cmd_step - STEP_FIRST];
            next_query_param = ram_par[cmd_seq][cmd_step - STEP_FIRST];
          end
        end
        OSSE_CMD_RUN:
        begin
          next_cmd_error = !seq_ok;
          if (seq_ok)
          begin
            next_state      = OSSE_FETCH;
            next_pc_seq     = cmd_seq;
            next_pc_step    = STEP_FIRST;
            next_exec_fault = 1'b0;
            st_clear        = 1'b1;
          end
        end
        default:          next_cmd_error = 1'b1;
      endcase
    end
    else if (cmd_valid)
      next_cmd_error = (cmd_code != OSSE_CMD_RESUME)
                       || (state != OSSE_PAUSED);
    case (state)
      OSSE_IDLE:   ;
      OSSE_FETCH:
      begin
        next_cur_type = ram_type[pc_seq][pc_step - STEP_FIRST];
        next_cur_par  = ram_par[pc_seq][pc_step - STEP_FIRST];
        next_state    = OSSE_EXEC;
      end
      OSSE_EXEC:
      begin
        next_state   = OSSE_FETCH;
        next_pc_step = pc_step + STEP_FIRST;
        case (cur_type)
          OSSE_LOOP:
          begin
            // A zero count is pushed too, so its next still pairs with it.
            if (st_full)
            begin
              next_state      = OSSE_FAULT;
              next_exec_fault = 1'b1;
            end
            else
              st_push = 1'b1;
          end
          OSSE_NEXT:
          begin
            if (st_empty)
            begin
              next_state      = OSSE_FAULT;
              next_exec_fault = 1'b1;
            end
            else if (st_count > 16'h0001)
            begin
              st_dec       = 1'b1;
              next_pc_seq  = st_seq;
              next_pc_step = st_step + STEP_FIRST;
            end
            else
              st_pop = 1'b1;
          end
          OSSE_GOTO:
          begin
            next_pc_seq  = cur_par[SEQ_W-1:0];
            next_pc_step = STEP_FIRST;
            if (cur_par >= PARAM_W'(SEQS) || !in_use[cur_par[SEQ_W-1:0]])
            begin
              next_state      = OSSE_FAULT;
              next_exec_fault = 1'b1;
            end
          end
          OSSE_PAUSE:  next_state = OSSE_PAUSED;
          OSSE_STOP,
          OSSE_RETURN: next_state = OSSE_IDLE;
          OSSE_OUTPUT:
          begin
            next_out_strobe = 1'b1;
            next_out_param  = cur_par;
          end
          default:     ;
        endcase
        // Running past the last step without a branch ends the sequence.
        if (next_state == OSSE_FETCH && next_pc_step > STEP_LAST)
          next_state = OSSE_IDLE;
      end
      OSSE_PAUSED:
        if (cmd_valid && cmd_code == OSSE_CMD_RESUME)
          next_state = OSSE_FETCH;
      OSSE_FAULT:  next_state = OSSE_IDLE;
      default:     next_state = OSSE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state       <= OSSE_IDLE;
      pc_seq      <= '0;
      pc_step     <= STEP_FIRST;
      cur_type    <= OSSE_EMPTY;
      cur_par     <= '0;
      cmd_error   <= 1'b0;
      query_valid <= 1'b0;
      query_type  <= OSSE_EMPTY;
      query_param <= '0;
      running     <= 1'b0;
      paused      <= 1'b0;
      out_strobe  <= 1'b0;
      out_param   <= '0;
      exec_fault  <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      pc_seq      <= next_pc_seq;
      pc_step     <= next_pc_step;
      cur_type    <= next_cur_type;
      cur_par     <= next_cur_par;
      cmd_error   <= next_cmd_error;
      query_valid <= next_query_valid;
      query_type  <= next_query_type;
      query_param <= next_query_param;
      running     <= (next_state != OSSE_IDLE);
      paused      <= (next_state == OSSE_PAUSED);
      out_strobe  <= next_out_strobe;
      out_param   <= next_out_param;
      exec_fault  <= next_exec_fault;
    end
  end

  property p_pause_holds;
    @(posedge clk_sys) disable iff (rst)
    (state == OSSE_PAUSED && !(cmd_valid && cmd_code == OSSE_CMD_RESUME))
    |=> state == OSSE_PAUSED;
  endproperty
  a_pause_holds: assert property (p_pause_holds)
    else $error("pause left without resume");

  sequence s_resume_taken;
    state == OSSE_PAUSED && cmd_valid && cmd_code == OSSE_CMD_RESUME;
  endsequence

  property p_resume;
    @(posedge clk_sys) disable iff (rst)
    s_resume_taken |=> state == OSSE_FETCH && !paused;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not restart the sequence");

  property p_stop_idle;
    @(posedge clk_sys) disable iff (rst)
    (state == OSSE_EXEC && cur_type == OSSE_STOP) |=> state == OSSE_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not halt");

  property p_query;
    @(posedge clk_sys) disable iff (rst)
    (cmd_valid && state == OSSE_IDLE && cmd_code == OSSE_CMD_QUERY
     && seq_ok && step_ok) |=> query_valid;
  endproperty
  a_query: assert property (p_query)
    else $error("query gave no answer");

  property p_bad_define;
    @(posedge clk_sys) disable iff (rst)
    (cmd_valid && state == OSSE_IDLE && cmd_code == OSSE_CMD_DEFINE
     && !step_ok) |=> cmd_error;
  endproperty
  a_bad_define: assert property (p_bad_define)
    else $error("out of range define not flagged");

  property p_del_all;
    @(posedge clk_sys) disable iff (rst)
    do_del_all |=> in_use == '0;
  endproperty
  a_del_all: assert property (p_del_all)
    else $error("delete all left sequences");

  property p_alloc;
    @(posedge clk_sys) disable iff (rst)
    do_alloc |=> in_use[$past(free_slot)];
  endproperty
  a_alloc: assert property (p_alloc)
    else $error("allocation not marked");

  property p_goto;
    @(posedge clk_sys) disable iff (rst)
    (state == OSSE_EXEC && cur_type == OSSE_GOTO) |=> pc_step == STEP_FIRST;
  endproperty
  a_goto: assert property (p_goto)
    else $error("goto not at first step");

  property p_next_back;
    @(posedge clk_sys) disable iff (rst)
    (state == OSSE_EXEC && cur_type == OSSE_NEXT && !st_empty
     && st_count > 16'h0001) |=> pc_step == $past(st_step) + STEP_FIRST;
  endproperty
  a_next_back: assert property (p_next_back)
    else $error("next did not return to loop body");
endmodule // osse_engine

// ### tb/osse_host_model.sv
// Host-side model that issues engine commands one transfer at a time.
module osse_host_model
  import osse_pkg::*;
(
  input  wire logic               clk_sys,
  output logic                    cmd_valid,
  output logic      [3:0]         cmd_code,
  output logic      [SEQ_W-1:0]   cmd_seq,
  output logic      [STEP_W-1:0]  cmd_step,
  output logic      [TYPE_W-1:0]  cmd_type,
  output logic      [PARAM_W-1:0] cmd_param
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_valid = 1'b0;
    cmd_code  = 4'h0;
    cmd_seq   = '0;
    cmd_step  = '0;
    cmd_type  = '0;
    cmd_param = 16'h0000;
  end

  // Fields are inverted once the transfer is taken, so stale values never
  // pass for the next request.
  task automatic send(input logic [3:0] code, input int s, st, t, p);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_seq   <= SEQ_W'(s);
    cmd_step  <= STEP_W'(st);
    cmd_type  <= TYPE_W'(t);
    cmd_param <= PARAM_W'(p);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
    cmd_seq   <= ~SEQ_W'(s);
    cmd_step  <= ~STEP_W'(st);
    cmd_type  <= ~TYPE_W'(t);
    cmd_param <= ~PARAM_W'(p);
  endtask
endmodule // osse_host_model

// ### tb/output_sequence_step_engine_bench.sv
// Self-checking bench for the sequence step engine.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  $display("unexpected at %0t: got %0h want %0h", $time, g, e); \
  n_errors++; end end
module output_sequence_step_engine_bench
  import osse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, cmd_error, query_valid, running, paused;
  logic out_strobe, exec_fault;
  logic [3:0] cmd_code;
  logic [SEQ_W-1:0] cmd_seq;
  logic [STEP_W-1:0] cmd_step;
  logic [TYPE_W-1:0] cmd_type, query_type;
  logic [PARAM_W-1:0] cmd_param, query_param, out_param;
  int n_errors = 0;
  int cmp_count = 0;
  int ty[MAX_SEQ][32];
  int pa[MAX_SEQ][32];
  bit used[MAX_SEQ];
  logic [15:0] r = 16'h3414;

  always #4 clk_sys = ~clk_sys;

  osse_host_model i_osse_host_model (
    .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_seq(cmd_seq), .cmd_step(cmd_step), .cmd_type(cmd_type),
    .cmd_param(cmd_param));

  osse_engine i_osse_engine (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_seq(cmd_seq), .cmd_step(cmd_step),
    .cmd_type(cmd_type), .cmd_param(cmd_param), .cmd_error(cmd_error),
    .query_valid(query_valid), .query_type(query_type),
    .query_param(query_param), .running(running), .paused(paused),
    .out_strobe(out_strobe), .out_param(out_param),
    .exec_fault(exec_fault));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic bit ok_step(input int t, st);
    if (st < 1 || st > MAX_STEP)
      return 0;
    return !(t inside {OSSE_PAUSE, OSSE_LOOP, OSSE_NEXT, OSSE_OUTPUT}
             && st > PAUSE_LAST);
  endfunction

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Issues one command, predicts refusal and query data, then updates the
  // reference copy of the storage.
  task automatic cmd(input osse_cmd_t c, input int s = 0, st = 0, t = 0,
                     input int p = 0);
    bit err;
    bit qv;
    logic [TYPE_W-1:0] qt;
    logic [PARAM_W-1:0] qp;
    int e;
    int n;
    int k;
    n = 0;
    foreach (used[i]) n += used[i];
    case (c)
      OSSE_CMD_DEFINE: e = !used[s] || !ok_step(t, st);
      OSSE_CMD_QUERY:  e = !used[s] || st < 1 || st > MAX_STEP;
      OSSE_CMD_ALLOC:  e = (n == MAX_SEQ);
      OSSE_CMD_DEL_ALL: e = 0;
      OSSE_CMD_DEL_SEL, OSSE_CMD_SAVE: e = !used[s];
      OSSE_CMD_RESUME: e = 1;
      default: e = -1;
    endcase
    i_osse_host_model.send(c, s, st, t, p);
    err = 0;
    qv = 0;
    repeat (4)
    begin
      #1;
      if (cmd_error === 1'b1) err = 1;
      if (query_valid === 1'b1)
      begin
        qv = 1;
        qt = query_type;
        qp = query_param;
      end
      @(posedge clk_sys);
    end
    if (e >= 0) `CHK(err, 1'(e))
    if (c == OSSE_CMD_QUERY && e == 0)
    begin
      `CHK(qv, 1'b1)
      `CHK(qt, TYPE_W'(ty[s][st]))
      if (ty[s][st] inside {OSSE_LOOP, OSSE_GOTO, OSSE_OUTPUT})
        `CHK(qp, PARAM_W'(pa[s][st]))
    end
    if (e <= 0)
      case (c)
        OSSE_CMD_DEFINE:
        begin
          ty[s][st] = t;
          pa[s][st] = p;
        end
        OSSE_CMD_ALLOC:
        begin
          for (k = 0; used[k]; k++);
          used[k] = 1;
          foreach (ty[k][j]) ty[k][j] = OSSE_EMPTY;
          ty[k][MAX_STEP] = OSSE_STOP;
        end
        OSSE_CMD_DEL_SEL: used[s] = 0;
        OSSE_CMD_DEL_ALL: used = '{default: 0};
        default: ;
      endcase
  endtask

  // Runs a slot, resuming each pause, and compares against the reference.
  task automatic run(input int s);
    int q[$];
    logic [15:0] got[$];
    int ss[NEST_DEPTH], sst[NEST_DEPTH], sc[NEST_DEPTH];
    int flt, np, npz, sp, cs, st, t, p, g, i;
    bit seen, pz;
    cs = s;
    st = 1;
    sp = 0;
    flt = 0;
    np = 0;
    for (g = 0; g < 5000 && st <= MAX_STEP; g++)
    begin
      t = ty[cs][st];
      p = pa[cs][st];
      st++;
      if (t == OSSE_STOP || t == OSSE_RETURN) break;
      else if (t == OSSE_OUTPUT) q.push_back(p);
      else if (t == OSSE_PAUSE) np++;
      else if (t == OSSE_GOTO)
      begin
        if (!used[p]) begin flt = 1; break; end
        cs = p;
        st = 1;
      end
      else if (t == OSSE_LOOP)
      begin
        if (sp == NEST_DEPTH) begin flt = 1; break; end
        ss[sp] = cs;
        sst[sp] = st;
        sc[sp] = (p > 1) ? p : 1;
        sp++;
      end
      else if (t == OSSE_NEXT)
      begin
        if (sp == 0) begin flt = 1; break; end
        if (sc[sp-1] > 1)
        begin
          sc[sp-1]--;
          cs = ss[sp-1];
          st = sst[sp-1];
        end
        else
          sp--;
      end
    end
    i_osse_host_model.send(OSSE_CMD_RUN, s, 0, 0, 0);
    seen = 0;
    pz = 0;
    npz = 0;
    for (i = 0; i < 3000; i++)
    begin
      #1;
      if (running === 1'b1) seen = 1;
      if (out_strobe === 1'b1) got.push_back(out_param);
      if (seen && running === 1'b0) break;
      if (paused === 1'b1 && !pz)
      begin
        npz++;
        i_osse_host_model.send(OSSE_CMD_RESUME, 0, 0, 0, 0);
      end
      else
        @(posedge clk_sys);
      pz = (paused === 1'b1);
    end
    if (i == 3000)
    begin
      n_errors++;
      end_sim();
    end
    `CHK(got.size(), q.size())
    foreach (q[k])
      if (k < got.size()) `CHK(got[k], PARAM_W'(q[k]))
    `CHK(npz, np)
    `CHK(exec_fault, 1'(flt))
    if (q.size() > 0) `CHK(out_param, PARAM_W'(q[$]))
  endtask

  int bt[8] = '{OSSE_PAUSE, OSSE_OUTPUT, OSSE_LOOP, OSSE_NEXT, OSSE_STOP,
                OSSE_GOTO, OSSE_STOP, OSSE_GOTO};
  int bs[8] = '{21, 21, 21, 21, 0, 22, 21, 21};
  // Loop in slot 0 closes in slot 1; every next follows its loop.
  int ps[13] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1};
  int pst[13] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 1, 2, 3};
  int pt[13] = '{OSSE_LOOP, OSSE_OUTPUT, OSSE_LOOP, OSSE_OUTPUT, OSSE_NEXT,
                 OSSE_NEXT, OSSE_PAUSE, OSSE_OUTPUT, OSSE_LOOP, OSSE_GOTO,
                 OSSE_OUTPUT, OSSE_NEXT, OSSE_STOP};
  int pp[13] = '{3, 0, 2, 0, 0, 0, 0, 0, 2, 1, 0, 0, 0};

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK(running, 1'b0)
    `CHK(paused, 1'b0)
    `CHK(exec_fault, 1'b0)
    `CHK(query_valid, 1'b0)
    cmd(OSSE_CMD_ALLOC);
    cmd(OSSE_CMD_ALLOC);
    cmd(OSSE_CMD_QUERY, 0, 21);
    foreach (bt[i])
      cmd(OSSE_CMD_DEFINE, 0, bs[i], bt[i], 1);
    cmd(OSSE_CMD_QUERY, 0, 21);
    foreach (pt[i])
    begin
      r = lfsr(r);
      cmd(OSSE_CMD_DEFINE, ps[i], pst[i], pt[i],
          (pt[i] == OSSE_OUTPUT) ? int'(r) : pp[i]);
    end
    foreach (pt[i])
      cmd(OSSE_CMD_QUERY, ps[i], pst[i]);
    run(0);
    cmd(OSSE_CMD_ALLOC);
    for (int i = 1; i <= NEST_DEPTH + 1; i++)
      cmd(OSSE_CMD_DEFINE, 2, i, OSSE_LOOP, 1);
    run(2);
    cmd(OSSE_CMD_DEFINE, 2, 1, OSSE_GOTO, 40);
    run(2);
    cmd(OSSE_CMD_RESUME);
    repeat (48) cmd(OSSE_CMD_ALLOC);
    cmd(OSSE_CMD_DEL_SEL, 0);
    cmd(OSSE_CMD_ALLOC);
    cmd(OSSE_CMD_QUERY, 0, 1);
    cmd(OSSE_CMD_QUERY, 0, 21);
    cmd(OSSE_CMD_SAVE, 1);
    cmd(OSSE_CMD_QUERY, 1, 11);
    cmd(OSSE_CMD_DEL_ALL);
    cmd(OSSE_CMD_QUERY, 1, 21);
    end_sim();
  end
endmodule // output_sequence_step_engine_bench
